/* File: core/pmsd_defs.svh */
// Constants for the paged memory space decoder: address windows, control
// window offsets, space mapping bit positions and reset values.
// Assumes a 16-bit host address and an 8-bit host data bus.
`ifndef PMSD_DEFS_SVH
`define PMSD_DEFS_SVH

// Address windows of the decode equations.
`define PMSD_MAIN_COMMON_BASE 16'h4000
`define PMSD_PAGED_LOW_BASE 16'h8000
`define PMSD_PAGED_HIGH_BASE 16'hC000
`define PMSD_MAIN_SPAN 16'h3FFF
`define PMSD_BOOT_BASE 16'h0000
`define PMSD_BOOT_STEP 16'h2000
`define PMSD_BOOT_SPAN 16'h1FFF
`define PMSD_SRAM_BASE 16'h2000
`define PMSD_SRAM_SPAN 16'h07FF
`define PMSD_CTRL_BASE 16'h2800
`define PMSD_CTRL_SPAN 16'h00FF

// Offsets inside the control register window.
`define PMSD_OFF_PAGE 8'h00
`define PMSD_OFF_SPACE 8'h01
`define PMSD_OFF_STATUS 8'h02
`define PMSD_OFF_MC_LO 8'h10
`define PMSD_OFF_MC_HI 8'h11
`define PMSD_OFF_IL0 8'h18
`define PMSD_OFF_IL1 8'h19
`define PMSD_OFF_IL2 8'h1A

// Space mapping register bits.
`define PMSD_MAP_MAIN_PROG 0
`define PMSD_MAP_MAIN_DATA 1
`define PMSD_MAP_BOOT_PROG 2
`define PMSD_MAP_BOOT_DATA 3

// Reset values.
`define PMSD_MAP_RESET 4'h0
`define PMSD_PAGE_RESET 2'h0

`endif

/* File: core/pmsd_pkg.sv */
// Types shared by the paged memory space decoder.
// Assumes pmsd_defs.svh is on the include path.
package pmsd_pkg;

  // Start-up sequence: the space mapping loads once after reset.
  typedef enum logic [1:0] {
    PMSD_PHASE_INIT = 2'h0,
    PMSD_PHASE_RUN = 2'h1
  } pmsd_state_t;

  // Complete registered state of the decoder.
  typedef struct packed {
    pmsd_state_t phase;
    logic [1:0] page;
    logic [3:0] space_map;
    logic [15:0] mc;
    logic [23:0] il;
    logic wr_n_prev;
    logic [7:0] main_sel;
    logic [3:0] boot_sel;
    logic sram_sel;
    logic ctrl_sel;
    logic [7:0] rdata;
    logic jtag_grant;
    logic [15:0] gpl_addr;
    logic [7:0] gpl_data;
    logic [2:0] gpl_ctrl;
  } pmsd_regs_t;

endpackage

/* File: core/pmsd_decoder.sv */
// Paged memory space decoder: sector selects, control window, logic block
// access, security gating of the programming port.
// Assumes host strobes and address are synchronous to core_clk.
`timescale 1ns/10ps
`include "pmsd_defs.svh"

// Operation
// - Eight main flash sectors, each its own select.
// - Four boot sectors, each selected individually.
// - One SRAM select, one control window select.
// - Memory arrays are selected one at a time, never concurrently.
// - Sector selected only on matching address.
// - Page register joins address in decoding.
// - Space mapping places flash in program/data.
// - Space mapping loads nonvolatile value after reset.
// - Host may rewrite space mapping at runtime.
// - Program and data are separate 64K spaces.
// - 16 macrocells, 24 latches host accessible.
// - Host bus signals routed to programmable logic.
// - Security refuses external programmer access.
// - Boundary-scan programs all areas without host; here it only raises jtag_grant, with no programming path.
// - SRAM and control window only in data.
// - Two page bits reach the decode.
module pmsd_decoder (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic psen_n,
  input wire logic [3:0] nv_space_init,
  input wire logic [23:0] latch_in,
  input wire logic security_set,
  input wire logic jtag_req,
  output logic [7:0] main_flash_sector_select,
  output logic [3:0] boot_sector_select,
  output logic sram_select,
  output logic ctrl_select,
  output logic [7:0] host_rdata,
  output logic [15:0] macrocell_out,
  output logic [15:0] gpl_addr,
  output logic [7:0] gpl_data,
  output logic [2:0] gpl_ctrl,
  output logic [3:0] space_mapping_register,
  output logic jtag_grant
);

  pmsd_pkg::pmsd_regs_t r;
  pmsd_pkg::pmsd_regs_t next_r;

  // Inclusive window test shared by every decode equation.
  function automatic logic in_win(input logic [15:0] a, input logic [15:0] base,
                                  input logic [15:0] span);
    in_win = (a >= base) && (a <= 16'(base + span));
  endfunction

  logic prog_cyc;
  logic data_cyc;
  logic wr_cyc;
  logic main_ok;
  logic boot_ok;
  logic [7:0] main_hit;
  logic [3:0] boot_hit;
  logic sram_hit;
  logic ctrl_hit;
  logic wr_edge;
  logic [7:0] off;

  // Space qualifiers: a fetch lives in program space, reads and writes in data.
  assign prog_cyc = !psen_n;
  assign data_cyc = psen_n && (!rd_n || !wr_n);
  assign wr_cyc = psen_n && !wr_n;
  assign off = host_addr[7:0];
  assign wr_edge = wr_cyc && r.wr_n_prev;

  // Mapping gate per memory; writes only reach what sits in data space.
  always_comb begin
    main_ok = (prog_cyc && r.space_map[`PMSD_MAP_MAIN_PROG] && rd_n && wr_n)
      || (data_cyc && r.space_map[`PMSD_MAP_MAIN_DATA]);
    boot_ok = (prog_cyc && r.space_map[`PMSD_MAP_BOOT_PROG] && rd_n && wr_n)
      || (data_cyc && r.space_map[`PMSD_MAP_BOOT_DATA]);
  end

  // Decode equations; the page bits split the upper windows into banks.
  always_comb begin
    main_hit = 8'h00;
    main_hit[0] = in_win(host_addr, `PMSD_PAGED_LOW_BASE, `PMSD_MAIN_SPAN) && r.page == 2'h3;
    main_hit[1] = in_win(host_addr, `PMSD_MAIN_COMMON_BASE, `PMSD_MAIN_SPAN);
    for (int i = 1; i < 4; i++) begin
      main_hit[2*i] = in_win(host_addr, `PMSD_PAGED_LOW_BASE, `PMSD_MAIN_SPAN)
        && r.page == 2'(i - 1);
      main_hit[2*i+1] = in_win(host_addr, `PMSD_PAGED_HIGH_BASE, `PMSD_MAIN_SPAN)
        && r.page == 2'(i - 1);
    end
    for (int j = 0; j < 4; j++) begin
      boot_hit[j] = in_win(host_addr, 16'(`PMSD_BOOT_BASE + j * `PMSD_BOOT_STEP),
        `PMSD_BOOT_SPAN);
    end
    sram_hit = data_cyc && in_win(host_addr, `PMSD_SRAM_BASE, `PMSD_SRAM_SPAN);
    ctrl_hit = data_cyc && in_win(host_addr, `PMSD_CTRL_BASE, `PMSD_CTRL_SPAN);
  end

  // Next state: selects with fixed priority, control window, start-up load.
  always_comb begin
    next_r = r;
    next_r.wr_n_prev = !wr_cyc;
    // Priority ctrl > SRAM > boot > main keeps one select alive when maps overlap.
    next_r.ctrl_sel = ctrl_hit;
    next_r.sram_sel = sram_hit && !ctrl_hit;
    next_r.boot_sel = (boot_ok && !sram_hit && !ctrl_hit) ? boot_hit : 4'h0;
    next_r.main_sel = (main_ok && !sram_hit && !ctrl_hit && boot_hit == 4'h0
                       || main_ok && !boot_ok && !sram_hit && !ctrl_hit)
                      ? main_hit : 8'h00;
    // Each array has its own select, yet the priority above keeps at most one active.
    next_r.il = latch_in;
    // The latches follow their pins unless the host has just written one.
    if (r.phase == pmsd_pkg::PMSD_PHASE_INIT) begin
      next_r.space_map = nv_space_init;
      next_r.phase = pmsd_pkg::PMSD_PHASE_RUN;
    end else if (ctrl_hit && wr_edge) begin
      unique case (off)
        `PMSD_OFF_PAGE: next_r.page = host_wdata[1:0];
        `PMSD_OFF_SPACE: next_r.space_map = host_wdata[3:0];
        `PMSD_OFF_MC_LO: next_r.mc[7:0] = host_wdata;
        `PMSD_OFF_MC_HI: next_r.mc[15:8] = host_wdata;
        `PMSD_OFF_IL0: next_r.il[7:0] = host_wdata;
        `PMSD_OFF_IL1: next_r.il[15:8] = host_wdata;
        `PMSD_OFF_IL2: next_r.il[23:16] = host_wdata;
        default: next_r.phase = r.phase;
      endcase
    end
    // Reads of the window return the block's own state; others read zero.
    next_r.rdata = 8'h00;
    if (ctrl_hit && !rd_n) begin
      unique case (off)
        `PMSD_OFF_PAGE: next_r.rdata = {6'h00, r.page};
        `PMSD_OFF_SPACE: next_r.rdata = {4'h0, r.space_map};
        `PMSD_OFF_STATUS: next_r.rdata = {6'h00, r.jtag_grant, security_set};
        `PMSD_OFF_MC_LO: next_r.rdata = r.mc[7:0];
        `PMSD_OFF_MC_HI: next_r.rdata = r.mc[15:8];
        `PMSD_OFF_IL0: next_r.rdata = r.il[7:0];
        `PMSD_OFF_IL1: next_r.rdata = r.il[15:8];
        `PMSD_OFF_IL2: next_r.rdata = r.il[23:16];
        default: next_r.rdata = 8'h00;
      endcase
    end
    // Bus mirror for the programmable logic.
    next_r.gpl_addr = host_addr;
    next_r.gpl_data = host_wdata;
    next_r.gpl_ctrl = {psen_n, wr_n, rd_n};
    // The boundary-scan port needs no host and no loaded map, only no lock.
    next_r.jtag_grant = jtag_req && !security_set;
  end

  // One register stage holds the whole state; reset gives constants only.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.phase <= pmsd_pkg::PMSD_PHASE_INIT;
      r.space_map <= `PMSD_MAP_RESET;
      r.page <= `PMSD_PAGE_RESET;
      r.wr_n_prev <= 1'b1;
      r.gpl_ctrl <= 3'h7;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state flops.
  assign main_flash_sector_select = r.main_sel;
  assign boot_sector_select = r.boot_sel;
  assign sram_select = r.sram_sel;
  assign ctrl_select = r.ctrl_sel;
  assign host_rdata = r.rdata;
  assign macrocell_out = r.mc;
  assign gpl_addr = r.gpl_addr;
  assign gpl_data = r.gpl_data;
  assign gpl_ctrl = r.gpl_ctrl;
  assign space_mapping_register = r.space_map;
  assign jtag_grant = r.jtag_grant;

  // Checks on the registered selects, map and grant against the bus one cycle earlier.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  one_select_a: assert property (
    $countones({r.main_sel, r.boot_sel, r.sram_sel, r.ctrl_sel}) <= 1)
    else $error("More than one memory select active.");
  main_needs_map_a: assert property (
    r.main_sel != 8'h00 |-> $past(main_ok))
    else $error("Main flash selected outside its mapped space.");
  write_prog_a: assert property (
    (!wr_n && psen_n && !r.space_map[`PMSD_MAP_MAIN_DATA]) |=> r.main_sel == 8'h00)
    else $error("Write selected a program-only main flash.");
  sram_data_a: assert property (
    !psen_n |=> !r.sram_sel && !r.ctrl_sel)
    else $error("SRAM or control window selected by a fetch.");
  page_bank_a: assert property (
    r.main_sel[2] |-> $past(r.page) == 2'h0 && $past(host_addr[15:14]) == 2'h2)
    else $error("Paged sector selected with the wrong page or address.");
  // The first edge after release still shows the reset map, so the check waits for the load.
  map_load_a: assert property (
    $past(r.phase) == pmsd_pkg::PMSD_PHASE_INIT && r.phase == pmsd_pkg::PMSD_PHASE_RUN
    |-> r.space_map == $past(nv_space_init))
    else $error("Space mapping did not load its initial value.");
  map_write_a: assert property (
    (r.phase == pmsd_pkg::PMSD_PHASE_RUN && wr_edge && ctrl_hit && off == `PMSD_OFF_SPACE)
    |=> r.space_map == $past(host_wdata[3:0]) ##1 r.space_map == $past(r.space_map))
    else $error("Space mapping write was not applied.");
  secure_block_a: assert property (
    security_set |=> !r.jtag_grant)
    else $error("Programmer access granted while secured.");
  boot_hit_a: assert property (
    r.boot_sel[1] |-> $past(host_addr[15:13]) == 3'h1)
    else $error("Boot sector selected on a foreign address.");

  fetch_boot_c: cover property (!psen_n ##1 r.boot_sel[0]);
  paged_read_c: cover property (r.page == 2'h2 ##1 r.main_sel[7]);
  remap_c: cover property (wr_edge && ctrl_hit && off == `PMSD_OFF_SPACE ##2 r.main_sel != 8'h00);
  jtag_c: cover property (jtag_req ##1 r.jtag_grant);

endmodule

/* File: testbench/pmsd_host_model.sv */
// Host microcontroller model that drives the decoder's demultiplexed bus.
// Assumes a free running core_clk and a testbench that calls its tasks.
`timescale 1ns/10ps
module pmsd_host_model (
  input wire logic core_clk,
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  output logic rd_n,
  output logic wr_n,
  output logic psen_n
);
  // The bus starts idle with every strobe high.
  initial begin
    {psen_n, wr_n, rd_n} = 3'h7;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
  end
  // One access with strobes {psen_n, wr_n, rd_n}, held over its sampling edge.
  task acc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    {psen_n, wr_n, rd_n} = k;
    host_addr = a;
    host_wdata = d;
    @(posedge core_clk);
    #1;
  endtask
  // Released lines do not keep their last value, so they turn over here.
  task idle();
    @(posedge core_clk);
    #1;
    {psen_n, wr_n, rd_n} = 3'h7;
    host_addr = ~host_addr;
    host_wdata = ~host_wdata;
  endtask
endmodule

/* File: testbench/paged_memory_space_decoder_tb.sv */
// Self-checking bench for the paged memory space decoder.
// Assumes the host model drives the bus and the start mapping is 4'h6.
`timescale 1ns/10ps
module paged_memory_space_decoder_tb;
  logic core_clk, reset, security_set, jtag_req;
  logic rd_n, wr_n, psen_n, sram_select, ctrl_select, jtag_grant;
  logic [15:0] host_addr, macrocell_out, gpl_addr;
  logic [7:0] host_wdata, main_flash_sector_select, host_rdata, gpl_data;
  logic [3:0] boot_sector_select, space_mapping_register;
  logic [2:0] gpl_ctrl;
  logic [23:0] latch_in;
  logic [3:0] nv_init;
  int bad_count = 0;
  int total_checks = 0;
  pmsd_host_model i_pmsd_host_model (.core_clk(core_clk), .host_addr(host_addr),
    .host_wdata(host_wdata), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n));
  pmsd_decoder i_pmsd_decoder (.core_clk(core_clk), .reset(reset), .host_addr(host_addr),
    .host_wdata(host_wdata), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n),
    .nv_space_init(nv_init), .latch_in(latch_in), .security_set(security_set),
    .jtag_req(jtag_req), .main_flash_sector_select(main_flash_sector_select),
    .boot_sector_select(boot_sector_select), .sram_select(sram_select),
    .ctrl_select(ctrl_select), .host_rdata(host_rdata), .macrocell_out(macrocell_out),
    .gpl_addr(gpl_addr), .gpl_data(gpl_data), .gpl_ctrl(gpl_ctrl),
    .space_mapping_register(space_mapping_register), .jtag_grant(jtag_grant));
  // A 20 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Main flash selects for a data access, for the paged window layout.
  function automatic logic [7:0] exp_main(input logic [1:0] p, input logic [15:0] a);
    exp_main = 8'h00;
    if (a[15:14] == 2'h1) exp_main = 8'h02;
    else if (a[15:14] == 2'h2) exp_main = (p == 2'h3) ? 8'h01 : 8'h04 << {p, 1'b0};
    else if (a[15:14] == 2'h3 && p != 2'h3) exp_main = 8'h08 << {p, 1'b0};
  endfunction
  // One decoded access; the bus mirror must follow the same access.
  task sel(input logic [2:0] k, input logic [15:0] a, input logic [7:0] em,
           input logic [3:0] eb, input logic es, input logic ec);
    i_pmsd_host_model.acc(k, a, 8'h00);
    chk({main_flash_sector_select, boot_sector_select, sram_select, ctrl_select},
        {em, eb, es, ec});
    chk({15'h0000, $onehot0({main_flash_sector_select, boot_sector_select,
        sram_select, ctrl_select})}, 16'h0001);
    chk(gpl_addr, a);
    chk({13'h0000, gpl_ctrl}, {13'h0000, k});
    i_pmsd_host_model.idle();
  endtask
  task wr(input logic [7:0] off, input logic [7:0] d);
    i_pmsd_host_model.acc(3'h5, {8'h28, off}, d);
    chk({8'h00, gpl_data}, {8'h00, d});
    i_pmsd_host_model.idle();
  endtask
  task rd(input logic [7:0] off, input logic [7:0] e);
    i_pmsd_host_model.acc(3'h6, {8'h28, off}, 8'h00);
    chk({8'h00, host_rdata}, {8'h00, e});
    i_pmsd_host_model.idle();
  endtask
  task t_reset();
    @(posedge core_clk);
    #1;
    chk({12'h000, space_mapping_register}, 16'h0006);
    chk({15'h0000, jtag_grant}, 16'h0000);
  endtask
  // Boot memory answers fetches; SRAM and the control window answer data.
  task t_spaces();
    for (int j = 0; j < 4; j++) begin
      sel(3'h3, 16'(16'h2000 * j), 8'h00, 4'h1 << j, 1'b0, 1'b0);
    end
    sel(3'h6, 16'h0000, 8'h00, 4'h0, 1'b0, 1'b0);
    sel(3'h6, 16'h2000, 8'h00, 4'h0, 1'b1, 1'b0);
    sel(3'h6, 16'h28FF, 8'h00, 4'h0, 1'b0, 1'b1);
    sel(3'h3, 16'h2800, 8'h00, 4'h2, 1'b0, 1'b0);
  endtask
  // Pages 0 to 2 steer both paged windows to their own sectors; page 3 only the low one.
  task t_page();
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'(p));
      rd(8'h00, 8'(p));
      sel(3'h6, 16'h8000, exp_main(2'(p), 16'h8000), 4'h0, 1'b0, 1'b0);
      sel(3'h6, 16'hFFFF, exp_main(2'(p), 16'hFFFF), 4'h0, 1'b0, 1'b0);
      sel(3'h6, 16'h4000, 8'h02, 4'h0, 1'b0, 1'b0);
    end
    wr(8'h00, 8'h00);
  endtask
  // Main flash moved to program space only; writes may not reach it.
  task t_remap();
    wr(8'h01, 8'h01);
    sel(3'h5, 16'h4000, 8'h00, 4'h0, 1'b0, 1'b0);
    sel(3'h3, 16'h4000, 8'h02, 4'h0, 1'b0, 1'b0);
    sel(3'h3, 16'h0000, 8'h00, 4'h0, 1'b0, 1'b0);
    wr(8'h01, 8'h06);
    chk({12'h000, space_mapping_register}, 16'h0006);
  endtask
  task t_logic();
    wr(8'h10, 8'hA5);
    wr(8'h11, 8'h3C);
    chk(macrocell_out, 16'h3CA5);
    rd(8'h11, 8'h3C);
    latch_in = 24'h123456;
    rd(8'h18, 8'h56);
    rd(8'h1A, 8'h12);
    rd(8'hFF, 8'h00);
  endtask
  // The programming port is granted without the host unless locked.
  task t_secure();
    jtag_req = 1'b1;
    rd(8'h02, 8'h02);
    chk({15'h0000, jtag_grant}, 16'h0001);
    security_set = 1'b1;
    rd(8'h02, 8'h01);
    chk({15'h0000, jtag_grant}, 16'h0000);
  endtask
  // A reset in mid-run must reload a different nonvolatile map and decode by it.
  task t_rereset();
    nv_init = 4'h9;
    reset = 1'b1;
    @(posedge core_clk);
    #1;
    chk({12'h000, space_mapping_register}, 16'h0000);
    reset = 1'b0;
    @(posedge core_clk);
    #1;
    chk({12'h000, space_mapping_register}, 16'h0009);
    sel(3'h3, 16'h4000, 8'h02, 4'h0, 1'b0, 1'b0);
    sel(3'h6, 16'h0000, 8'h00, 4'h1, 1'b0, 1'b0);
  endtask
  // Cuts a hang short well after the expected run of about 140 cycles.
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    security_set = 1'b0;
    jtag_req = 1'b0;
    latch_in = 24'h000000;
    nv_init = 4'h6;
    repeat (5) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_spaces();
    t_page();
    t_remap();
    t_logic();
    t_secure();
    t_rereset();
    print_verdict();
  end
endmodule
